// file: logic/sleep_gate_pkg.sv
// package: register map, field positions and types of the sleep clock gate block
package sleep_gate_pkg;
    localparam logic [11:0] SLEEP_ENABLE_OFS = 12'h114; // sleep_unit_clock_enable
    localparam logic [11:0] AUTO_GATE_OFS = 12'h200;    // auto_gate_select control
    localparam logic [11:0] FAULT_STATUS_OFS = 12'h204; // sticky fault events
    localparam logic [11:0] FAULT_MASK_OFS = 12'h208;   // interrupt mask
    localparam logic [11:0] GATE_STATE_OFS = 12'h20c;   // delivered enables
    localparam int SERIAL_A_BIT = 0;
    localparam int SERIAL_B_BIT = 1;
    localparam int SYNC_SERIAL_BIT = 4;
    localparam int TWO_WIRE_BIT = 12;
    localparam int TIMER_A_BIT = 16;
    localparam int TIMER_B_BIT = 17;
    localparam int TIMER_C_BIT = 18;
    localparam int COMP_A_BIT = 24;
    localparam int COMP_B_BIT = 25;
    localparam logic [31:0] WRITABLE_MASK = 32'h0307_1013;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam int UNIT_COUNT = 9;
    // power state reported by the system controller
    typedef enum logic [2:0] {
        PWR_RUN = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_DEEP = 3'b100
    } power_state_t;
    // access request towards the selected gated units, one select bit per unit
    typedef struct packed {
        logic [UNIT_COUNT-1:0] sel;
        logic valid;
    } unit_access_t;
endpackage : sleep_gate_pkg

// file: logic/sleep_gate.sv
// sleep-mode unit clock enable register with gate outputs and fault logic
`timescale 1ns/100ps
module sleep_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sleep_gate_pkg::power_state_t power_state,
    input wire logic [8:0] run_enable,
    input wire logic [8:0] deep_enable,
    input wire sleep_gate_pkg::unit_access_t unit_access,
    output logic [8:0] unit_clock_en,
    output logic bus_fault,
    output logic irq
);
    logic [31:0] enable_q;
    logic auto_gate_q;
    logic [8:0] status_q;
    logic [8:0] mask_q;
    logic [8:0] gate_q;
    logic [8:0] sleep_vec;
    logic [8:0] gate_d;
    logic [8:0] fault_hit;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;

    // write strobe in the access phase, read strobe in setup; every transfer answers in its first access cycle
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign addr_ok = (paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS)
        || (paddr == sleep_gate_pkg::AUTO_GATE_OFS)
        || (paddr == sleep_gate_pkg::FAULT_STATUS_OFS)
        || (paddr == sleep_gate_pkg::FAULT_MASK_OFS)
        || (paddr == sleep_gate_pkg::GATE_STATE_OFS);

    // compact per-unit view of the sleep enables
    assign sleep_vec = {enable_q[sleep_gate_pkg::COMP_B_BIT],
                        enable_q[sleep_gate_pkg::COMP_A_BIT],
                        enable_q[sleep_gate_pkg::TIMER_C_BIT],
                        enable_q[sleep_gate_pkg::TIMER_B_BIT],
                        enable_q[sleep_gate_pkg::TIMER_A_BIT],
                        enable_q[sleep_gate_pkg::TWO_WIRE_BIT],
                        enable_q[sleep_gate_pkg::SYNC_SERIAL_BIT],
                        enable_q[sleep_gate_pkg::SERIAL_B_BIT],
                        enable_q[sleep_gate_pkg::SERIAL_A_BIT]};

    // enable register; only documented bits are writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= sleep_gate_pkg::ENABLE_RESET;
        end else if (wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS) begin
            enable_q <= pwdata & sleep_gate_pkg::WRITABLE_MASK;
        end
    end

    // automatic gating select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gate_q <= 1'b0;
        end else if (wr_acc && paddr == sleep_gate_pkg::AUTO_GATE_OFS) begin
            auto_gate_q <= pwdata[0];
        end
    end

    // gate selection by power state
    always_comb begin
        case (power_state)
            sleep_gate_pkg::PWR_SLEEP: gate_d = auto_gate_q ? sleep_vec : run_enable;
            sleep_gate_pkg::PWR_DEEP: gate_d = auto_gate_q ? deep_enable : run_enable;
            default: gate_d = run_enable;
        endcase
    end

    // registered clock enables for the units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 9'h000;
        end else begin
            gate_q <= gate_d;
        end
    end
    assign unit_clock_en = gate_q;

    // fault when any selected unit is unclocked
    assign fault_hit = unit_access.valid ? (unit_access.sel & ~gate_q) : 9'h000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= |fault_hit;
        end
    end

    // sticky status, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 9'h000;
        end else if (wr_acc && paddr == sleep_gate_pkg::FAULT_STATUS_OFS) begin
            status_q <= (status_q & ~pwdata[8:0]) | fault_hit;
        end else begin
            status_q <= status_q | fault_hit;
        end
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 9'h000;
        end else if (wr_acc && paddr == sleep_gate_pkg::FAULT_MASK_OFS) begin
            mask_q <= pwdata[8:0];
        end
    end

    // interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // read data captured in setup so it is valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            if (paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS) begin
                prdata <= enable_q;
            end else if (paddr == sleep_gate_pkg::AUTO_GATE_OFS) begin
                prdata <= {31'h0, auto_gate_q};
            end else if (paddr == sleep_gate_pkg::FAULT_STATUS_OFS) begin
                prdata <= {23'h0, status_q};
            end else if (paddr == sleep_gate_pkg::FAULT_MASK_OFS) begin
                prdata <= {23'h0, mask_q};
            end else if (paddr == sleep_gate_pkg::GATE_STATE_OFS) begin
                prdata <= {23'h0, gate_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ready and error valid in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // register content, gating and fault checks
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_q & ~sleep_gate_pkg::WRITABLE_MASK) == 32'h0)
        else $error("reserved enable bit set");
    a_reset_clear: assert property (@(posedge pclk)
        !presetn |=> enable_q == 32'h0 || !presetn)
        else $error("enable not cleared by reset");
    a_timer_c_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS |=> enable_q[18] == $past(pwdata[18]))
        else $error("timer c enable not written");
    a_serial_a_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS |=> enable_q[0] == $past(pwdata[0]))
        else $error("serial a enable not written");
    a_comp_b_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS |=> enable_q[25] == $past(pwdata[25]))
        else $error("comparator b enable not written");
    a_sleep_gating: assert property (@(posedge pclk) disable iff (!presetn)
        power_state == sleep_gate_pkg::PWR_SLEEP && auto_gate_q |=> gate_q == $past(sleep_vec))
        else $error("sleep enables not applied");
    a_run_gating: assert property (@(posedge pclk) disable iff (!presetn)
        power_state == sleep_gate_pkg::PWR_RUN |=> gate_q == $past(run_enable))
        else $error("run enables not applied");
    a_fault_raise: assert property (@(posedge pclk) disable iff (!presetn)
        unit_access.valid && |(unit_access.sel & ~gate_q) |=> bus_fault)
        else $error("no fault for stopped unit");
    a_fault_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !unit_access.valid |=> !bus_fault)
        else $error("spurious bus fault");

    // setup cycle of an apb transfer
    sequence s_setup;
        psel && !penable;
    endsequence

    // ready stands for exactly one access cycle
    sequence s_ready_pulse;
        pready ##1 !pready;
    endsequence

    // write strobe aimed at the sleep enable register
    sequence s_enable_write;
        wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS;
    endsequence

    // write strobe aimed at the fault status register
    sequence s_status_write;
        wr_acc && paddr == sleep_gate_pkg::FAULT_STATUS_OFS;
    endsequence

    // every setup is answered in the next cycle, zero wait states
    a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> s_ready_pulse)
        else $error("ready pulse missing after setup");

    // ready never rises without a setup cycle before it
    a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel && !penable))
        else $error("ready without setup");

    // unmapped addresses are refused with an error response
    a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##0 !addr_ok |=> pslverr)
        else $error("no error for unmapped address");

    // mapped addresses complete without error
    a_error_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##0 addr_ok |=> !pslverr)
        else $error("error for mapped address");

    // the error response only stands together with ready
    a_error_alone: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    // timer b enable follows the written bit
    a_timer_b_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[17] == $past(pwdata[17]))
        else $error("timer b enable not written");

    // timer a enable follows the written bit
    a_timer_a_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[16] == $past(pwdata[16]))
        else $error("timer a enable not written");

    // two-wire port enable follows the written bit
    a_two_wire_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[12] == $past(pwdata[12]))
        else $error("two-wire enable not written");

    // sync serial enable follows the written bit
    a_sync_serial_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[4] == $past(pwdata[4]))
        else $error("sync serial enable not written");

    // serial port b enable follows the written bit
    a_serial_b_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[1] == $past(pwdata[1]))
        else $error("serial b enable not written");

    // comparator a enable follows the written bit
    a_comp_a_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_write |=> enable_q[24] == $past(pwdata[24]))
        else $error("comparator a enable not written");

    // without a write the enables keep their value
    a_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS) |=> $stable(enable_q))
        else $error("enable register changed without write");

    // a read of the enables returns the register as it stood in setup
    a_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##0 (!pwrite && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS)
        |=> prdata == $past(enable_q))
        else $error("enable read data wrong");

    // reserved positions of the enable register read as zero
    a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##0 (!pwrite && paddr == sleep_gate_pkg::SLEEP_ENABLE_OFS)
        |=> (prdata & ~sleep_gate_pkg::WRITABLE_MASK) == 32'h0)
        else $error("reserved bit read as one");

    // sleep without automatic gating delivers the run enables
    a_auto_off_gating: assert property (@(posedge pclk) disable iff (!presetn)
        power_state == sleep_gate_pkg::PWR_SLEEP && !auto_gate_q
        |=> gate_q == $past(run_enable))
        else $error("sleep enables used without auto gating");

    // deep sleep with automatic gating delivers the deep sleep enables
    a_deep_gating: assert property (@(posedge pclk) disable iff (!presetn)
        power_state == sleep_gate_pkg::PWR_DEEP && auto_gate_q
        |=> gate_q == $past(deep_enable))
        else $error("deep sleep enables not applied");

    // a fault event sets its status bit even while software clears it
    a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
        |fault_hit |=> (status_q & $past(fault_hit)) == $past(fault_hit))
        else $error("fault status not set");

    // writing ones clears the status bits when no event collides
    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_status_write ##0 (fault_hit == 9'h000)
        |=> (status_q & $past(pwdata[8:0])) == 9'h000)
        else $error("fault status not cleared");

    // status holds when there is neither event nor clear
    a_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == sleep_gate_pkg::FAULT_STATUS_OFS) && fault_hit == 9'h000
        |=> $stable(status_q))
        else $error("fault status changed by itself");

    // the interrupt level follows the unmasked status one cycle later
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == |($past(status_q) & $past(mask_q)))
        else $error("interrupt level wrong");

    // no fault is reported for accesses to clocked units
    a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
        fault_hit == 9'h000 |=> !bus_fault)
        else $error("fault for clocked unit");

    // the mask register takes the written value
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == sleep_gate_pkg::FAULT_MASK_OFS |=> mask_q == $past(pwdata[8:0]))
        else $error("mask not written");

    // the automatic gating select takes the written bit
    a_auto_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == sleep_gate_pkg::AUTO_GATE_OFS |=> auto_gate_q == $past(pwdata[0]))
        else $error("auto gate select not written");
endmodule : sleep_gate

// file: verif/gated_units_model.sv
// partner model: gated units that raise bus accesses on request
`timescale 1ns/100ps
module gated_units_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [8:0] hit,
    output sleep_gate_pkg::unit_access_t unit_access
);
    // one access selecting all requested units, following hit one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_access <= '0;
        end else begin
            unit_access.sel <= hit;
            unit_access.valid <= |hit;
        end
    end
endmodule : gated_units_model

// file: verif/tb_sleep_gate.sv
// testbench: register map, gate selection, fault and interrupt path
`timescale 1ns/100ps
module tb_sleep_gate;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_fault, irq, seen, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [8:0] run_enable, deep_enable, unit_clock_en, hit;
    sleep_gate_pkg::power_state_t power_state;
    sleep_gate_pkg::unit_access_t unit_access;
    int num_errors = 0;
    int total_checks = 0;
    int pos[9] = '{0, 1, 4, 12, 16, 17, 18, 24, 25};
    sleep_gate sleep_gate_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_state(power_state), .run_enable(run_enable),
        .deep_enable(deep_enable), .unit_access(unit_access), .unit_clock_en(unit_clock_en),
        .bus_fault(bus_fault), .irq(irq));
    gated_units_model gated_units_model_inst (.pclk(pclk), .presetn(presetn), .hit(hit),
        .unit_access(unit_access));
    // clock generation
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // compares one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) num_errors++;
    endtask : apb
    task automatic settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    // asks the partner for one access and watches for a fault
    task automatic probe(input logic [8:0] m);
        @(posedge pclk);
        hit <= m;
        @(posedge pclk);
        hit <= 9'h000;
        seen = 1'b0;
        repeat (4) begin
            @(negedge pclk);
            seen |= bus_fault;
        end
    endtask : probe
    task automatic test_reset;
        chk(unit_clock_en, 32'h0);
        apb(1'b0, sleep_gate_pkg::SLEEP_ENABLE_OFS, 32'h0);
        chk(rv, 32'h0);
        chk(err, 1'b0);
    endtask : test_reset
    // reset in mid-run clears every enable and output
    task automatic test_midreset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({irq, bus_fault, unit_clock_en}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, sleep_gate_pkg::SLEEP_ENABLE_OFS, 32'h0);
        chk(rv, 32'h0);
    endtask : test_midreset
    // one unit at a time, updated by read-modify-write
    task automatic test_map;
        apb(1'b1, sleep_gate_pkg::SLEEP_ENABLE_OFS, 32'hffff_ffff);
        apb(1'b0, sleep_gate_pkg::SLEEP_ENABLE_OFS, 32'h0);
        chk(rv, 32'h0307_1013);
        apb(1'b1, sleep_gate_pkg::AUTO_GATE_OFS, 32'h1);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, sleep_gate_pkg::SLEEP_ENABLE_OFS, 32'h0);
            apb(1'b1, sleep_gate_pkg::SLEEP_ENABLE_OFS, (rv & 32'hfcf8_efec) | (32'h1 << pos[i]));
            settle();
            chk(unit_clock_en, 32'h1 << i);
        end
    endtask : test_map
    task automatic test_state;
        @(posedge pclk);
        power_state <= sleep_gate_pkg::PWR_RUN;
        settle();
        chk(unit_clock_en, 32'h0aa);
        @(posedge pclk);
        power_state <= sleep_gate_pkg::PWR_SLEEP;
        apb(1'b1, sleep_gate_pkg::AUTO_GATE_OFS, 32'h0);
        settle();
        chk(unit_clock_en, 32'h0aa);
        apb(1'b1, sleep_gate_pkg::AUTO_GATE_OFS, 32'h1);
        settle();
        chk(unit_clock_en, 32'h100);
        @(posedge pclk);
        power_state <= sleep_gate_pkg::PWR_DEEP;
        settle();
        chk(unit_clock_en, 32'h155);
        @(posedge pclk);
        power_state <= sleep_gate_pkg::PWR_SLEEP;
        settle();
        chk(unit_clock_en, 32'h100);
    endtask : test_state
    task automatic test_fault;
        apb(1'b1, sleep_gate_pkg::FAULT_MASK_OFS, 32'h1ff);
        probe(9'h001);
        chk(seen, 1'b1);
        apb(1'b0, sleep_gate_pkg::FAULT_STATUS_OFS, 32'h0);
        chk(rv, 32'h1);
        chk(irq, 1'b1);
        probe(9'h100);
        chk(seen, 1'b0);
        apb(1'b1, sleep_gate_pkg::FAULT_STATUS_OFS, 32'h1);
        apb(1'b0, sleep_gate_pkg::FAULT_STATUS_OFS, 32'h0);
        chk({rv[30:0], irq}, 32'h0);
        apb(1'b1, sleep_gate_pkg::FAULT_MASK_OFS, 32'h0);
        probe(9'h001);
        chk(irq, 1'b0);
        apb(1'b0, 12'h300, 32'h0);
        chk({rv[30:0], err}, 32'h1);
    endtask : test_fault
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // watchdog against a hung handshake
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, hit} = '0;
        power_state = sleep_gate_pkg::PWR_SLEEP;
        run_enable = 9'h0aa;
        deep_enable = 9'h155;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_map();
        test_state();
        test_fault();
        test_midreset();
        complete_run();
    end
endmodule : tb_sleep_gate
